// ===== ars_adc_model.sv
/* model of the adc result datapath feeding the block.
   assumes the bench calls send from its main sequence. */
`timescale 1ns/10ps
`include "ars_params.svh"

module ars_adc_model (
    input wire logic clk_i, // system clock
    output logic [`ARS_DATA_W-1:0] adc_result_o, // conversion result
    output logic adc_valid_o // one-cycle strobe
);
    // ****************************************************************
    // result stream
    // ****************************************************************
    initial begin
        adc_result_o = '0;
        adc_valid_o = 1'b0;
    end
    // stale data shows inverted so it never passes for a result
    task automatic send(input logic [`ARS_DATA_W-1:0] v);
        @(posedge clk_i);
        adc_valid_o <= 1'b1;
        adc_result_o <= v;
        @(posedge clk_i);
        adc_valid_o <= 1'b0;
        adc_result_o <= ~v;
    endtask
endmodule // ars_adc_model

// ===== ars_checker.sv
/* port checker of the result statistics block.
   assumes it is bound to ars_result_stats and sees only its ports. */
`timescale 1ns/10ps
`include "ars_params.svh"

module ars_checker (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic [`ARS_ADR_W-1:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic wb_we_i, // write when high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic [`ARS_DATA_W-1:0] adc_result_i, // result
    input wire logic adc_valid_i, // result strobe
    input wire logic irq_o // interrupt
);
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
    property p_rst_out;
        $fell(rst_i) |-> !wb_ack_o && !irq_o && wb_dat_o == 32'h0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
    property p_ctrl_hi;
        wb_ack_o && !wb_we_i && wb_adr_i == `ARS_OFS_CONTROL |-> wb_dat_o[31:12] == 20'h0;
    endproperty
    a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");
    property p_mean_hi;
        wb_ack_o && !wb_we_i && wb_adr_i == `ARS_OFS_MEAN |-> wb_dat_o[31:16] == 16'h0;
    endproperty
    a_mean_hi: assert property (p_mean_hi) else $error("mean upper bits set");
    property p_var_hi;
        wb_ack_o && !wb_we_i && wb_adr_i == `ARS_OFS_VARIANCE |-> !wb_dat_o[31];
    endproperty
    a_var_hi: assert property (p_var_hi) else $error("variance bit 31 set");
    property p_irq_rise;
        $rose(irq_o) |-> $past(adc_valid_i) || $past(adc_valid_i, 2)
            || ($past(wb_ack_o) && $past(wb_we_i))
            || ($past(wb_ack_o, 2) && $past(wb_we_i, 2));
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
    property p_irq_fall;
        $fell(irq_o) |-> ($past(wb_ack_o) && $past(wb_we_i))
            || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)) || $past(rst_i);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
endmodule // ars_checker

bind ars_result_stats ars_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .adc_result_i(adc_result_i), .adc_valid_i(adc_valid_i), .irq_o(irq_o));

// ===== ars_params.svh
/*
 * Constants of the ADC result statistics and delta check block: register byte offsets,
 * field positions, reset values and count limits.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ARS_ADR_W 14
`define ARS_OFS_STEP_LIMIT 14'h20b8
`define ARS_OFS_VARIANCE 14'h21c0
`define ARS_OFS_CONTROL 14'h21c4
`define ARS_OFS_MEAN 14'h21c8
`define ARS_OFS_IRQ_STATUS 14'h21d0
`define ARS_OFS_IRQ_CLEAR 14'h21d4
`define ARS_OFS_IRQ_ENABLE 14'h21d8

// ****************************************************************
// field positions and widths
// ****************************************************************
`define ARS_DATA_W 16
`define ARS_VAR_W 31
`define ARS_CTRL_W 12
`define ARS_CTRL_EN_BIT 0
`define ARS_CTRL_SIZE_LSB 4
`define ARS_CTRL_SIZE_MSB 6
`define ARS_IRQ_W 8
`define ARS_IRQ_DELTA_BIT 6
`define ARS_IRQ_STATS_BIT 7

// ****************************************************************
// reset values and counts
// ****************************************************************
`define ARS_RST_STEP_LIMIT 16'h0000
`define ARS_RST_CONTROL 12'h000
`define ARS_RST_IRQ 8'h00
`define ARS_RST_WORD 32'h0000_0000
`define ARS_CNT_W 7
`define ARS_SUM_W 23
`define ARS_SQ_W 39
`define ARS_WIDE_W 46
`define ARS_SHIFT_MAX 3'h7
`define ARS_SIZE_LAST 3'h4

`endif

// ===== ars_pkg.sv
/*
 * Types of the ADC result statistics and delta check block.
 * Assumes ars_params.svh supplies the widths.
 */
`include "ars_params.svh"

package ars_pkg;

    // one request of the register bus
    typedef struct packed {
        logic [`ARS_ADR_W-1:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic req;
    } ars_bus_req_type;

    // software view of the control register
    typedef struct packed {
        logic [4:0] dev_cfg;
        logic [2:0] size_sel;
        logic [2:0] spare;
        logic stats_on;
    } ars_ctrl_type;

    // block end result
    typedef struct packed {
        logic [`ARS_DATA_W-1:0] mean;
        logic [`ARS_VAR_W-1:0] variance;
    } ars_stats_type;

endpackage

// ===== ars_result_stats.sv
/*
 * ADC result post-processing: delta check between consecutive results, and mean and
 * variance over blocks of 8 to 128 samples, with a classic Wishbone register slave and
 * one level interrupt.
 * Assumes adc results arrive on clk_i from logic in the same clock domain, one per
 * strobe, and a Wishbone classic master that holds its request until ack.
 */
// How it works
// - each new result is compared to the previous; bigger step than limit flags error
// - control bit 0 turns statistics on, control register resets to zero
// - sample-size field 0..4 picks 128, 64, 32, 16 or 8 samples per block
// - mean register holds the 16-bit average of the last completed block
// - variance register holds 31-bit spread about the mean, bit 31 reads zero
`timescale 1ns/10ps
`include "ars_params.svh"

module ars_result_stats (
    input wire logic clk_i, // system clock, 50 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [`ARS_ADR_W-1:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic wb_we_i, // write when high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // one-cycle acknowledge
    input wire logic [`ARS_DATA_W-1:0] adc_result_i, // new conversion result
    input wire logic adc_valid_i, // one-cycle strobe with adc_result_i
    output logic irq_o // level interrupt
);

    // ****************************************************************
    // bus request
    // ****************************************************************
    ars_pkg::ars_bus_req_type bus_req;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic wr_take;
    logic [31:0] wmask;

    assign bus_req.adr = wb_adr_i;
    assign bus_req.dat = wb_dat_i;
    assign bus_req.sel = wb_sel_i;
    assign bus_req.we = wb_we_i;
    assign bus_req.req = wb_cyc_i & wb_stb_i;

    // write lands on the edge that the master samples ack
    assign wr_take = bus_req.req & bus_req.we & ack_ff;
    assign wmask = {{8{bus_req.sel[3]}}, {8{bus_req.sel[2]}},
                    {8{bus_req.sel[1]}}, {8{bus_req.sel[0]}}};

    // ****************************************************************
    // software registers
    // ****************************************************************
    logic [`ARS_DATA_W-1:0] step_limit_ff;
    ars_pkg::ars_ctrl_type ctrl_ff;
    logic [`ARS_IRQ_W-1:0] irq_en_ff;
    logic [`ARS_IRQ_W-1:0] irq_stat_ff;
    logic [`ARS_IRQ_W-1:0] nxt_irq_stat;
    logic [`ARS_IRQ_W-1:0] irq_set;
    logic [`ARS_IRQ_W-1:0] irq_clr;
    logic irq_ff;
    ars_pkg::ars_stats_type stats_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_limit_ff <= `ARS_RST_STEP_LIMIT;
        end else if (wr_take && bus_req.adr == `ARS_OFS_STEP_LIMIT) begin
            step_limit_ff <= (step_limit_ff & ~wmask[`ARS_DATA_W-1:0])
                             | (bus_req.dat[`ARS_DATA_W-1:0] & wmask[`ARS_DATA_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `ARS_RST_CONTROL;
        end else if (wr_take && bus_req.adr == `ARS_OFS_CONTROL) begin
            ctrl_ff <= (ctrl_ff & ~wmask[`ARS_CTRL_W-1:0])
                       | (bus_req.dat[`ARS_CTRL_W-1:0] & wmask[`ARS_CTRL_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_ff <= `ARS_RST_IRQ;
        end else if (wr_take && bus_req.adr == `ARS_OFS_IRQ_ENABLE) begin
            irq_en_ff <= (irq_en_ff & ~wmask[`ARS_IRQ_W-1:0])
                         | (bus_req.dat[`ARS_IRQ_W-1:0] & wmask[`ARS_IRQ_W-1:0]);
        end
    end

    // ****************************************************************
    // delta check
    // ****************************************************************
    logic [`ARS_DATA_W-1:0] prev_ff;
    logic prev_ok_ff;
    logic [`ARS_DATA_W-1:0] step;
    logic delta_hit;

    assign step = (adc_result_i >= prev_ff) ? (adc_result_i - prev_ff)
                                            : (prev_ff - adc_result_i);
    assign delta_hit = adc_valid_i & prev_ok_ff & (step > step_limit_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= `ARS_RST_STEP_LIMIT;
            prev_ok_ff <= 1'b0;
        end else if (adc_valid_i) begin
            prev_ff <= adc_result_i;
            prev_ok_ff <= 1'b1;
        end
    end

    // ****************************************************************
    // statistics accumulation
    // ****************************************************************
    logic [2:0] shift_k;
    logic [`ARS_CNT_W-1:0] last_idx;
    logic [`ARS_CNT_W-1:0] cnt_ff;
    logic [`ARS_SUM_W-1:0] sum_ff;
    logic [`ARS_SQ_W-1:0] sq_ff;
    logic done_ff;
    logic [`ARS_SUM_W-1:0] sum_base;
    logic [`ARS_SQ_W-1:0] sq_base;
    logic [`ARS_SQ_W-1:0] sample_sq;
    logic block_end;

    // unused size codes fall back to the smallest block
    always_comb begin
        if (ctrl_ff.size_sel > `ARS_SIZE_LAST) begin
            shift_k = `ARS_SHIFT_MAX - `ARS_SIZE_LAST;
        end else begin
            shift_k = `ARS_SHIFT_MAX - ctrl_ff.size_sel;
        end
    end

    assign last_idx = `ARS_CNT_W'((1 << shift_k) - 1);
    assign sample_sq = `ARS_SQ_W'(adc_result_i * adc_result_i);
    // a finished block is read out while the next one starts from zero
    assign sum_base = done_ff ? '0 : sum_ff;
    assign sq_base = done_ff ? '0 : sq_ff;
    assign block_end = ctrl_ff.stats_on & adc_valid_i & (cnt_ff >= last_idx);

    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_ff.stats_on) begin
            cnt_ff <= '0;
        end else if (adc_valid_i) begin
            cnt_ff <= block_end ? '0 : cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_ff.stats_on) begin
            sum_ff <= '0;
            sq_ff <= '0;
        end else if (adc_valid_i) begin
            sum_ff <= sum_base + `ARS_SUM_W'(adc_result_i);
            sq_ff <= sq_base + sample_sq;
        end else if (done_ff) begin
            sum_ff <= '0;
            sq_ff <= '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= block_end;
        end
    end

    // ****************************************************************
    // block results
    // ****************************************************************
    logic [`ARS_WIDE_W-1:0] n_sq;
    logic [`ARS_WIDE_W-1:0] sum_sq;
    logic [`ARS_WIDE_W-1:0] var_wide;
    logic [`ARS_SUM_W-1:0] mean_wide;

    // variance = (n * sum(x^2) - sum(x)^2) / n^2
    assign n_sq = `ARS_WIDE_W'(sq_ff) << shift_k;
    assign sum_sq = `ARS_WIDE_W'(sum_ff) * `ARS_WIDE_W'(sum_ff);
    assign var_wide = (n_sq - sum_sq) >> {shift_k, 1'b0};
    assign mean_wide = sum_ff >> shift_k;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stats_ff <= '0;
        end else if (done_ff) begin
            stats_ff.mean <= mean_wide[`ARS_DATA_W-1:0];
            stats_ff.variance <= var_wide[`ARS_VAR_W-1:0];
        end
    end

    // ****************************************************************
    // interrupt status, set wins over clear
    // ****************************************************************
    always_comb begin
        irq_set = '0;
        irq_set[`ARS_IRQ_DELTA_BIT] = delta_hit;
        irq_set[`ARS_IRQ_STATS_BIT] = done_ff;
        irq_clr = '0;
        if (wr_take && bus_req.adr == `ARS_OFS_IRQ_CLEAR) begin
            irq_clr = bus_req.dat[`ARS_IRQ_W-1:0] & wmask[`ARS_IRQ_W-1:0];
        end
        nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= `ARS_RST_IRQ;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_irq_stat & irq_en_ff);
        end
    end

    // ****************************************************************
    // bus answer
    // ****************************************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = `ARS_RST_WORD;
        unique case (bus_req.adr)
            `ARS_OFS_STEP_LIMIT: rd_mux = {16'h0000, step_limit_ff};
            `ARS_OFS_VARIANCE: rd_mux = {1'b0, stats_ff.variance};
            `ARS_OFS_CONTROL: rd_mux = {20'h00000, ctrl_ff};
            `ARS_OFS_MEAN: rd_mux = {16'h0000, stats_ff.mean};
            `ARS_OFS_IRQ_STATUS: rd_mux = {24'h000000, irq_stat_ff};
            `ARS_OFS_IRQ_ENABLE: rd_mux = {24'h000000, irq_en_ff};
            default: rd_mux = `ARS_RST_WORD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req.req & ~ack_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= `ARS_RST_WORD;
        end else if (bus_req.req && !ack_ff) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= `ARS_RST_WORD;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign irq_o = irq_ff;

endmodule // ars_result_stats

// ===== tb_top.sv
/* self-checking bench of the result statistics block.
   assumes ars_adc_model feeds the stream and ars_checker is bound. */
`timescale 1ns/10ps
`include "ars_params.svh"

module tb_top;
    logic clk_i;
    logic rst_i;
    logic [`ARS_ADR_W-1:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0] wb_sel_i;
    logic wb_we_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [`ARS_DATA_W-1:0] adc_result;
    logic adc_valid;
    logic irq_o;
    int miscompares;
    int checks_done;
    int cycles;
    logic [31:0] rdat;
    longint n;
    longint s;
    longint q;
    logic [15:0] x;
    logic [13:0] ofs [7] = '{`ARS_OFS_STEP_LIMIT, `ARS_OFS_VARIANCE, `ARS_OFS_CONTROL,
        `ARS_OFS_MEAN, `ARS_OFS_IRQ_STATUS, `ARS_OFS_IRQ_ENABLE, 14'h21e0};

    ars_result_stats dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .adc_result_i(adc_result), .adc_valid_i(adc_valid), .irq_o(irq_o));
    ars_adc_model adc (.clk_i(clk_i), .adc_result_o(adc_result), .adc_valid_o(adc_valid));

    // ****************************************************************
    // clock, timeout and tasks
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic bus(input logic [13:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_we_i <= w;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [13:0] a, input logic [31:0] exp);
        bus(a, 32'h0, 1'b0);
        chk(rdat, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_dat_i = '0;
        wb_sel_i = 4'hf;
        cycles = 0;
        miscompares = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ofs[i]) rchk(ofs[i], 32'h0);
        bus(`ARS_OFS_CONTROL, 32'hffff_fff0, 1'b1);
        rchk(`ARS_OFS_CONTROL, 32'h0000_0ff0);
        bus(`ARS_OFS_STEP_LIMIT, 32'hffff_000a, 1'b1);
        rchk(`ARS_OFS_STEP_LIMIT, 32'h0000_000a);
        wb_sel_i <= 4'h2;
        bus(`ARS_OFS_STEP_LIMIT, 32'hffff_00ff, 1'b1);
        wb_sel_i <= 4'hf;
        rchk(`ARS_OFS_STEP_LIMIT, 32'h0000_000a);
        bus(`ARS_OFS_IRQ_ENABLE, 32'h0000_00c0, 1'b1);
        adc.send(16'h0064);
        adc.send(16'h006e);
        rchk(`ARS_OFS_IRQ_STATUS, 32'h0);
        adc.send(16'h0079);
        rchk(`ARS_OFS_IRQ_STATUS, 32'h40);
        chk({31'h0, irq_o}, 32'h1);
        bus(`ARS_OFS_IRQ_CLEAR, 32'h40, 1'b1);
        rchk(`ARS_OFS_IRQ_STATUS, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        adc.send(16'h006e);
        rchk(`ARS_OFS_IRQ_STATUS, 32'h40);
        bus(`ARS_OFS_STEP_LIMIT, 32'h0000_ffff, 1'b1);
        // code 5 is unused and must behave as the 8-sample block
        for (int z = 5; z >= 0; z--) begin
            n = (z == 5) ? 8 : 128 >> z;
            s = 0;
            q = 0;
            bus(`ARS_OFS_IRQ_CLEAR, 32'hc0, 1'b1);
            bus(`ARS_OFS_CONTROL, 32'h1 | (z << 4), 1'b1);
            for (int i = 0; i < n; i++) begin
                x = 16'(i * 517 + z * 9001);
                s += x;
                q += longint'(x) * x;
                adc.send(x);
            end
            repeat (3) @(posedge clk_i);
            rchk(`ARS_OFS_MEAN, 32'(s / n));
            rchk(`ARS_OFS_VARIANCE, 32'((n * q - s * s) / (n * n)));
            rchk(`ARS_OFS_IRQ_STATUS, 32'h80);
            chk({31'h0, irq_o}, 32'h1);
        end
        // disabled: a full block of samples must leave the mean alone
        bus(`ARS_OFS_CONTROL, 32'h40, 1'b1);
        repeat (8) adc.send(16'h1234);
        repeat (3) @(posedge clk_i);
        rchk(`ARS_OFS_MEAN, 32'(s / n));
        bus(`ARS_OFS_IRQ_ENABLE, 32'h0, 1'b1);
        rchk(`ARS_OFS_IRQ_STATUS, 32'h80);
        chk({31'h0, irq_o}, 32'h0);
        // mid-run reset clears the registers again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(`ARS_OFS_CONTROL, 32'h0);
        rchk(`ARS_OFS_MEAN, 32'h0);
        rchk(`ARS_OFS_IRQ_STATUS, 32'h0);
        conclude();
    end
endmodule // tb_top
